// ### hpc_pkg.sv
// Shared constants and types of the host port control block
package hpc_pkg;

    // ========================================
    // Register indices (byte address = 4 x index)
    localparam logic [7:0] HPC_IDX_DATA   = 8'h08;
    localparam logic [7:0] HPC_IDX_PORT_E = 8'h09;
    localparam logic [7:0] HPC_IDX_IRQ    = 8'h0c;
    localparam logic [7:0] HPC_IDX_STATUS = 8'h89;
    localparam logic [7:0] HPC_IDX_ANALOG = 8'h9f;
    localparam logic [7:0] HPC_IDX_NONE   = 8'hff;
    localparam int         HPC_IDX_LSB    = 2;
    localparam int         HPC_IDX_MSB    = 9;

    // ========================================
    // Field positions
    localparam int HPC_BIT_IBF   = 7;
    localparam int HPC_BIT_OBF   = 6;
    localparam int HPC_BIT_INPUT_OVERRUN_FLAG  = 5;
    localparam int HPC_BIT_MODE  = 4;
    localparam int HPC_BIT_IRQ   = 7;
    localparam int HPC_PIN_RD    = 0;
    localparam int HPC_PIN_WR    = 1;
    localparam int HPC_PIN_CS    = 2;

    // ========================================
    // Reset values and masks
    localparam logic [2:0] HPC_DIR_RST     = 3'h7;
    localparam logic [7:0] HPC_ANALOG_RST  = 8'h00;
    localparam logic [7:0] HPC_ANALOG_MASK = 8'h8f;

    // ========================================
    // Quarter-cycle phases of the core clock
    localparam logic [1:0] HPC_PH_Q2 = 2'h1;
    localparam logic [1:0] HPC_PH_Q4 = 2'h3;

    // ========================================
    // Buffer shape
    localparam int HPC_FIFO_W = 8;
    localparam int HPC_FIFO_D = 16;

    // ========================================
    // Types
    typedef enum logic [2:0] {
        HPC_DN_IDLE = 3'b001,
        HPC_DN_Q2   = 3'b010,
        HPC_DN_Q4   = 3'b100
    } hpc_done_e;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } hpc_strobe_s;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } hpc_bus8_s;

    // Completion wait: next Q2, then the following Q4
    function automatic hpc_done_e hpc_done_step(hpc_done_e s, logic start,
                                                logic [1:0] ph);
        hpc_done_e n;
        n = s;
        case (s)
            HPC_DN_IDLE: begin
                if (start) n = HPC_DN_Q2;
            end
            HPC_DN_Q2: begin
                if (ph == HPC_PH_Q2) n = HPC_DN_Q4;
            end
            HPC_DN_Q4: begin
                if (ph == HPC_PH_Q4) n = HPC_DN_IDLE;
            end
            default: n = HPC_DN_IDLE;
        endcase
        return n;
    endfunction

endpackage

// ### hpc_sync.sv
// Two-flop synchroniser, one per bit
`timescale 1ns/10ps
module hpc_sync #(
    parameter int       W   = 3,
    parameter bit [7:0] RST_VAL = 8'hff
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_r <= RST_VAL[i];
                    q[i]   <= RST_VAL[i];
                end else begin
                    meta_r <= d[i];
                    q[i]   <= meta_r;
                end
            end
        end
    endgenerate
endmodule // hpc_sync

// ### hpc_fifo.sv
// Outgoing byte FIFO with valid/ready on both sides
`timescale 1ns/10ps
module hpc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } hpc_fifo_s;

    hpc_fifo_s s_r;
    hpc_fifo_s s_nxt;
    logic      push;
    logic      pop;

    assign in_ready  = (s_r.cnt != (AW+1)'(D));
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = (s_r.wp == AW'(D-1)) ? '0 : s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = (s_r.rp == AW'(D-1)) ? '0 : s_r.rp + 1'b1;
        end
        if (push & ~pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (pop & ~push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // hpc_fifo

// ### hpc_top.sv
// Host port control: byte latches, status flags and port-E pins
// Contract
// RL1: Output-full set until host reads byte
// RL2: Host write onto unread byte sets overrun
// RL3: Select bit enables host port mode
// RL4: Direction bits: 1 input, reset 1
// RL5: Read strobe low with select reads latch
// RL6: Write strobe low with select writes latch
// RL7: Chip select low enables; high ignores strobes
// RL8: Host mode: pins become read/write/select
// RL9: Unimplemented bits read as zero
// RL10: Write end sets input-full at Q4
// RL11: Input-full clears only on firmware read or outside host mode (RL13)
// RL12: Read start clears output-full; end flags
// RL13: Outside host mode full flags held clear
// RL14: Strobes synchronised before edge detection
`timescale 1ns/10ps
module hpc_top
    import hpc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Port-E pins
    input  wire logic [2:0]  PE_I,
    output logic      [2:0]  PE_O,
    output logic      [2:0]  PE_OE,
    // Host data bus
    input  wire logic [7:0]  HD_I,
    output logic      [7:0]  HD_O,
    output logic      [7:0]  HD_OE
);

    // ========================================
    // State
    typedef struct packed {
        logic        hready;
        logic        busy;
        logic        wr;
        logic [7:0]  idx;
        logic [31:0] rdata;
        logic        input_full_flag;
        logic        output_full_flag;
        logic        input_overrun_flag;
        logic        mode;
        logic [2:0]  dir;
        logic [7:0]  analog;
        logic [2:0]  pe_latch;
        logic        irq;
        logic [7:0]  in_latch;
        logic [7:0]  out_latch;
        logic        wr_act;
        logic        rd_act;
        logic [1:0]  phase;
        hpc_done_e   wst;
        hpc_done_e   rst_st;
        hpc_bus8_s   hd;
        logic [2:0]  pe_oe;
        logic [2:0]  pe_o;
    } hpc_state_s;

    hpc_state_s  s_r;
    hpc_state_s  s_nxt;
    hpc_strobe_s stb_raw;
    hpc_strobe_s stb_s;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;
    logic        sel;
    logic        wr_now;
    logic        rd_now;

    // ========================================
    // Strobe synchroniser
    assign stb_raw.cs_n = PE_I[HPC_PIN_CS]; // RL8
    assign stb_raw.wr_n = PE_I[HPC_PIN_WR]; // RL8
    assign stb_raw.rd_n = PE_I[HPC_PIN_RD]; // RL8

    hpc_sync #(
        .W       (3),
        .RST_VAL (8'hff)
    ) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   (stb_raw),
        .q   (stb_s)
    ); // RL14

    // ========================================
    // Outgoing byte FIFO
    // A full FIFO stalls the bus write rather than dropping the byte
    assign fifo_in_valid = s_r.busy & ~s_r.hready & s_r.wr &
                           (s_r.idx == HPC_IDX_DATA);
    // No load while a host read is active: the host must see one byte
    assign fifo_out_ready = s_r.mode & ~s_r.output_full_flag & ~s_r.rd_act & ~rd_now;

    hpc_fifo #(
        .W (HPC_FIFO_W),
        .D (HPC_FIFO_D)
    ) u_fifo (
        .clk       (CLK),
        .rst       (RST),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (HWDATA[7:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ========================================
    // Host access decode
    assign sel    = s_r.mode & ~stb_s.cs_n;  // RL3 RL7
    assign wr_now = sel & ~stb_s.wr_n;       // RL6
    assign rd_now = sel & ~stb_s.rd_n;       // RL5

    // ========================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.phase = s_r.phase + 2'h1;

        // Bus data phase, one wait state so reads see settled flags; a data write into a full FIFO waits until it has room
        if (s_r.busy & ~s_r.hready) begin
            if (s_r.wr) begin
                case (s_r.idx)
                    HPC_IDX_DATA: begin
                        if (fifo_in_ready) begin
                            s_nxt.busy   = 1'b0;
                            s_nxt.hready = 1'b1;
                        end
                    end
                    HPC_IDX_STATUS: begin
                        s_nxt.input_overrun_flag = HWDATA[HPC_BIT_INPUT_OVERRUN_FLAG];
                        s_nxt.mode = HWDATA[HPC_BIT_MODE];   // RL3
                        s_nxt.dir  = HWDATA[2:0];            // RL4
                    end
                    HPC_IDX_PORT_E: s_nxt.pe_latch = HWDATA[2:0];
                    HPC_IDX_IRQ:    s_nxt.irq = HWDATA[HPC_BIT_IRQ];
                    HPC_IDX_ANALOG: s_nxt.analog = HWDATA[7:0] &
                                                   HPC_ANALOG_MASK;
                    default: ;
                endcase
                if (s_r.idx != HPC_IDX_DATA) begin
                    s_nxt.busy   = 1'b0;
                    s_nxt.hready = 1'b1;
                end
            end else begin
                s_nxt.rdata = '0;                            // RL9
                case (s_r.idx)
                    HPC_IDX_DATA: begin
                        s_nxt.rdata[7:0] = s_r.in_latch;
                        s_nxt.input_full_flag        = 1'b0;             // RL11
                    end
                    HPC_IDX_STATUS: begin
                        s_nxt.rdata[HPC_BIT_IBF]  = s_r.input_full_flag;
                        s_nxt.rdata[HPC_BIT_OBF]  = s_r.output_full_flag; // RL1
                        s_nxt.rdata[HPC_BIT_INPUT_OVERRUN_FLAG] = s_r.input_overrun_flag;
                        s_nxt.rdata[HPC_BIT_MODE] = s_r.mode;
                        s_nxt.rdata[2:0]          = s_r.dir;
                    end
                    HPC_IDX_PORT_E: s_nxt.rdata[2:0] = PE_I; // RL9
                    HPC_IDX_IRQ:    s_nxt.rdata[HPC_BIT_IRQ] = s_r.irq;
                    HPC_IDX_ANALOG: s_nxt.rdata[7:0] = s_r.analog;
                    default: ;
                endcase
                s_nxt.busy   = 1'b0;
                s_nxt.hready = 1'b1;
            end
        end

        // Bus address phase
        if (HSEL & HTRANS[1] & HREADY) begin
            s_nxt.busy   = 1'b1;
            s_nxt.hready = 1'b0;
            s_nxt.wr     = HWRITE;
            s_nxt.idx    = (HADDR[31:HPC_IDX_MSB+1] == '0) ?
                           HADDR[HPC_IDX_MSB:HPC_IDX_LSB] : HPC_IDX_NONE;
        end

        // Host side edges, after software so a hardware set wins
        s_nxt.wr_act = wr_now;
        s_nxt.rd_act = rd_now;
        if (wr_now) begin
            s_nxt.in_latch = HD_I;                            // RL6
        end
        if (wr_now & ~s_r.wr_act & s_r.input_full_flag) begin
            s_nxt.input_overrun_flag = 1'b1;                                // RL2
        end
        if (rd_now & ~s_r.rd_act) begin
            s_nxt.output_full_flag = 1'b0;                                 // RL12
        end
        s_nxt.wst    = hpc_done_step(s_r.wst, s_r.wr_act & ~wr_now,
                                     s_r.phase);              // RL10
        s_nxt.rst_st = hpc_done_step(s_r.rst_st, s_r.rd_act & ~rd_now,
                                     s_r.phase);              // RL12
        if ((s_r.wst == HPC_DN_Q4) && (s_r.phase == HPC_PH_Q4)) begin
            s_nxt.input_full_flag = 1'b1;                                 // RL10
            s_nxt.irq = 1'b1;                                 // RL10
        end
        if ((s_r.rst_st == HPC_DN_Q4) && (s_r.phase == HPC_PH_Q4)) begin
            s_nxt.irq = 1'b1;                                 // RL12
        end

        // Next outgoing byte becomes visible to the host
        if (fifo_out_valid & fifo_out_ready) begin
            s_nxt.out_latch = fifo_out_data;
            s_nxt.output_full_flag       = 1'b1;                           // RL1
        end

        // Outside host mode the full flags stay clear, overrun is kept
        if (~s_r.mode) begin
            s_nxt.input_full_flag    = 1'b0;                              // RL13
            s_nxt.output_full_flag    = 1'b0;                              // RL13
            s_nxt.wst    = HPC_DN_IDLE;
            s_nxt.rst_st = HPC_DN_IDLE;
        end

        // Pin drive
        s_nxt.pe_oe = s_r.mode ? 3'h0 : ~s_r.dir;             // RL4 RL8
        s_nxt.pe_o  = s_r.pe_latch;
        s_nxt.hd.o  = s_r.out_latch;                          // RL5
        s_nxt.hd.oe = {8{rd_now}};                            // RL5 RL7
    end

    // ========================================
    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r        <= '0;
            s_r.hready <= 1'b1;
            s_r.dir    <= HPC_DIR_RST;                        // RL4
            s_r.analog <= HPC_ANALOG_RST;
            s_r.idx    <= HPC_IDX_NONE;
            s_r.wst    <= HPC_DN_IDLE;
            s_r.rst_st <= HPC_DN_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ========================================
    // Outputs
    assign HRDATA    = s_r.rdata;
    assign HREADYOUT = s_r.hready;
    assign HRESP     = 1'b0;
    assign PE_O      = s_r.pe_o;
    assign PE_OE     = s_r.pe_oe;
    assign HD_O      = s_r.hd.o;
    assign HD_OE     = s_r.hd.oe;

endmodule // hpc_top

// ### hpc_top_chk.sv
// Port checker of the host port control block
`timescale 1ns/10ps
module hpc_top_chk (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Observed ports
    input wire logic [31:0] HRDATA,
    input wire logic [2:0]  PE_I,
    input wire logic [2:0]  PE_OE,
    input wire logic [7:0]  HD_O,
    input wire logic [7:0]  HD_OE
);
    // ========
    // Host side and bus read data
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    property p_cs_idle;
        PE_I[2] [*4] |=> HD_OE == 8'h00;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("bus driven while unselected");
    property p_rd_idle;
        PE_I[0] [*4] |=> HD_OE == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("bus driven without read strobe");
    property p_rd_start;
        $rose(HD_OE[0]) |-> $past(PE_I[0] | PE_I[2], 3) == 1'b0
            || $past(PE_I[0] | PE_I[2], 4) == 1'b0;
    endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("drive began without a read");
    property p_rd_end;
        $fell(HD_OE[0]) |-> $past(PE_I[0] | PE_I[2], 3)
            || $past(PE_I[0] | PE_I[2], 4);
    endproperty
    a_rd_end: assert property (p_rd_end)
        else $error("drive ended inside a read");
    property p_oe_all;
        HD_OE == 8'h00 || HD_OE == 8'hff;
    endproperty
    a_oe_all: assert property (p_oe_all)
        else $error("partial bus drive");
    property p_pins_in;
        HD_OE != 8'h00 |-> PE_OE == 3'h0;
    endproperty
    a_pins_in: assert property (p_pins_in)
        else $error("strobe pin driven in host mode");
    property p_out_hold;
        HD_OE[0] && $past(HD_OE[0]) |-> $stable(HD_O);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("outgoing byte changed during read");
    property p_upper0;
        HRDATA[31:8] == 24'h000000;
    endproperty
    a_upper0: assert property (p_upper0)
        else $error("upper read bits not zero");
endmodule // hpc_top_chk

bind hpc_top hpc_top_chk u_chk (.CLK(CLK), .RST(RST), .HRDATA(HRDATA),
    .PE_I(PE_I), .PE_OE(PE_OE), .HD_O(HD_O), .HD_OE(HD_OE));

// ### hpc_host.sv
// Model of the external microprocessor on the host port
`timescale 1ns/10ps
module hpc_host (
    // Clock
    input  wire logic       clk,
    // Device drive
    input  wire logic [7:0] dev_o,
    input  wire logic [7:0] dev_oe,
    // Host drive and bus level
    output logic      [2:0] pe,
    output logic      [7:0] bus
);
    logic       drv;
    logic [7:0] val;
    logic [7:0] wdat;
    initial begin
        pe   = 3'h7;
        drv  = 1'b0;
        val  = 8'h00;
        wdat = 8'h00;
    end
    // Released bus toggles, so stale data never looks valid
    always @(posedge clk) if (!drv) val <= ~val;
    assign bus = (dev_oe != 8'h00) ? dev_o : (drv ? wdat : val);
    // Host write; sel_n high leaves the device unselected
    task automatic wr(input logic [7:0] b, input logic sel_n, input int hold);
        pe  <= {sel_n, 2'b01};
        drv  <= 1'b1;
        wdat <= b;
        repeat (hold) @(posedge clk);
        pe  <= 3'h7;
        // Data held past the strobe's trip through the synchroniser
        repeat (3) @(posedge clk);
        drv <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    // Host read, hold of four cycles or more
    task automatic rd(output logic [7:0] b, input int hold);
        pe <= 3'b010;
        repeat (hold) @(posedge clk);
        b = bus;
        pe <= 3'h7;
        repeat (12) @(posedge clk);
    endtask
endmodule // hpc_host

// ### hpc_top_test.sv
// Self-checking bench of the host port control block
`timescale 1ns/10ps
module hpc_top_test
    import hpc_pkg::*;
;
    logic        CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA, rv;
    logic [1:0]  HTRANS;
    logic [2:0]  PE_I, PE_O, PE_OE, host_pe;
    logic [7:0]  HD_I, HD_O, HD_OE, b;
    logic [7:0]  tx[18];
    logic [7:0]  q[$];
    int          fail_count, n_checks, cyc, seed, i;

    hpc_top dut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .PE_I(PE_I), .PE_O(PE_O), .PE_OE(PE_OE),
        .HD_I(HD_I), .HD_O(HD_O), .HD_OE(HD_OE));
    hpc_host host (.clk(CLK), .dev_o(HD_O), .dev_oe(HD_OE), .pe(host_pe),
        .bus(HD_I));
    assign PE_I = (PE_OE & PE_O) | (~PE_OE & host_pe);

    // ========
    // Clock, watchdog and reporting
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    // ========
    // Bus master: no wait count assumed
    task automatic bus(input logic w, input logic [7:0] x,
                       input logic [7:0] d, output logic [31:0] r);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HADDR  <= {22'h0, x, 2'b00};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= {24'h0, d};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask
    task automatic wr(input logic [7:0] x, input logic [7:0] d);
        bus(1'b1, x, d, rv);
    endtask
    task automatic rd(input string nm, input logic [7:0] x,
                      input logic [7:0] e);
        bus(1'b0, x, 8'h00, rv);
        chk(nm, e, rv[7:0]);
    endtask

    // ========
    // Scenarios
    initial begin
        seed = 32'hd2d6f3d1;
        fail_count = 0;
        n_checks = 0;
        cyc = 0;
        RST = 1'b1;
        {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rd("status", HPC_IDX_STATUS, 8'h07);
        rd("unmapped", 8'h40, 8'h00);
        wr(HPC_IDX_ANALOG, 8'hff);
        rd("analog", HPC_IDX_ANALOG, 8'h8f);
        wr(HPC_IDX_PORT_E, 8'hff);
        wr(HPC_IDX_STATUS, 8'h0a);
        rd("status", HPC_IDX_STATUS, 8'h02);
        repeat (2) @(posedge CLK);
        chk("pin oe", 8'h05, {5'h0, PE_OE});
        chk("pin out", 8'h05, {5'h0, PE_O & PE_OE});
        rd("port", HPC_IDX_PORT_E, 8'h07);
        wr(HPC_IDX_STATUS, 8'h17);
        rd("mode", HPC_IDX_STATUS, 8'h17);
        chk("host pins", 8'h00, {5'h0, PE_OE});
        chk("resp", 8'h00, {7'h0, HRESP});
        $display("test registers done");
        b = 8'($random(seed));
        host.wr(b, 1'b0, 3);
        rd("ibf", HPC_IDX_STATUS, 8'h97);
        rd("irq", HPC_IDX_IRQ, 8'h80);
        wr(HPC_IDX_STATUS, 8'h17);
        rd("ibf kept", HPC_IDX_STATUS, 8'h97);
        rd("in byte", HPC_IDX_DATA, b);
        rd("ibf clr", HPC_IDX_STATUS, 8'h17);
        $display("test host write done");
        host.wr(8'h5a, 1'b1, 3);
        rd("unsel", HPC_IDX_STATUS, 8'h17);
        host.wr(b, 1'b0, 2);
        host.wr(~b, 1'b0, 6);
        rd("ovr", HPC_IDX_STATUS, 8'hb7);
        wr(HPC_IDX_STATUS, 8'h27);
        rd("gpio", HPC_IDX_STATUS, 8'h27);
        wr(HPC_IDX_STATUS, 8'h17);
        rd("ovr clr", HPC_IDX_STATUS, 8'h17);
        $display("test overrun done");
        wr(HPC_IDX_IRQ, 8'h00);
        for (i = 0; i < 18; i++) begin
            tx[i] = 8'($random(seed));
            q.push_back(tx[i]);
        end
        wr(HPC_IDX_DATA, tx[0]);
        repeat (4) @(posedge CLK);
        rd("obf", HPC_IDX_STATUS, 8'h57);
        // Host stalls first, so the buffer must refuse a write
        fork
            for (int k = 1; k < 18; k++) wr(HPC_IDX_DATA, tx[k]);
            begin
                repeat (100) @(posedge CLK);
                repeat (18) begin
                    host.rd(b, 8);
                    chk("host byte", q.pop_front(), b);
                end
            end
        join
        rd("drained", HPC_IDX_STATUS, 8'h17);
        rd("rd irq", HPC_IDX_IRQ, 8'h80);
        $display("test outgoing done");
        close_out();
    end
endmodule // hpc_top_test
